// >>> common/sps_pkg.sv
// Constants and types for the setpoint program sequencer
package sps_pkg;
  localparam int NUM_PROGS = 8;
  localparam int NUM_SEGS = 12;
  localparam int LAST_END_SEG = 11;
  localparam int TRACKS = 4;
  localparam int SP_W = 16;
  localparam int DUR_W = 14;
  localparam logic [13:0] DUR_MAX = 14'h176F;
  localparam logic [13:0] DUR_END = 14'h3FFF;
  localparam logic [3:0] SEG_FIRST = 4'h0;
  localparam logic [15:0] SETTLE_BAND = 16'h0002;
  localparam int CLK_HZ = 25000000;
  localparam int ACK_TIME_S = 5;
  localparam int ACK_CYCLES = ACK_TIME_S * CLK_HZ;
  localparam int TICK_DIV = CLK_HZ;
  localparam logic [15:0] SP_RESET = 16'h0000;
  typedef enum logic [1:0] {
    SPS_IDLE = 2'b00,
    SPS_RUN = 2'b01,
    SPS_SETTLE = 2'b11,
    SPS_PAUSE = 2'b10
  } sps_state_e;
endpackage

// >>> rtl/sps_sequencer.sv
// Setpoint program sequencer core
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Stores eight programs of twelve segments each.
// - When enabled, setpoint comes solely from the sequencer.
// - Segment holds duration, target, tracks; end allowed after segments 1-11.
// - Idle keeps control outputs off and limit errors suppressed.
// - Idle loads momentary setpoint with actual value.
// - Starting after stop restarts program from the beginning.
// - Run enables outputs and limit errors, reports segment number.
// - Start always at segment 1 with actual value as start setpoint.
// - Configured start/stop input starts and stops the program.
// - With waiting on, segment end waits until deviation is 2 degrees.
// - Halt freezes setpoint and timing, reporting segment number.
// - Configured halt input halts the running program.
// - Track output asserted during segments selecting that track.
// - Outputs indicate running and halted states.
// - Display shows setpoint while running or halted, dashes when idle; no edits.
// - Status shows state and, except idle, current segment.
// - Keys change state only when no binary input controls it.
// - Key change needs acknowledge within 5 s, else or discard drops it.
// - Manual parameter entry and self-tuning blocked while enabled.
// - Duration ranges 0:00 to 99:59; end marker terminates program.
// - Ramp or step segment type selected for all programs.
module sps_sequencer #(
  parameter int ACK_CYCLES = sps_pkg::ACK_CYCLES,
  parameter int TICK_DIV = sps_pkg::TICK_DIV
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Configuration
  input wire logic sequencer_enable,
  input wire logic wait_enable_in,
  input wire logic jump_segment_type,
  input wire logic [2:0] sequencer_enable_sel_in,
  input wire logic start_input_cfg_in,
  input wire logic pause_input_cfg_in,
  // Program store write port
  input wire logic [3:0] seg_addr_in,
  input wire logic [13:0] seg_dur_in,
  input wire logic [15:0] seg_sp_in,
  input wire logic [3:0] seg_trk_in,
  input wire logic seg_we_in,
  // Pins
  input wire logic start_stop_pin_in,
  input wire logic external_pause_input,
  input wire logic key_up_in,
  input wire logic key_down_in,
  input wire logic key_ack_in,
  input wire logic key_discard_in,
  // Process value
  input wire logic [15:0] actual_in,
  // Outputs
  output logic [15:0] setpoint_out,
  output logic setpoint_dashes_out,
  output logic setpoint_lock_out,
  output logic tune_block_out,
  output logic ctrl_enable_out,
  output logic limit_err_enable_out,
  output logic [3:0] segment_flag_output,
  output logic run_ind_out,
  output logic pause_ind_out,
  output logic [1:0] status_state_out,
  output logic [3:0] status_seg_out,
  output logic key_pending_out
);

  ////////////////////////////////////////////////////////////////////////
  // Program store
  logic [13:0] dur_mem [0:sps_pkg::NUM_PROGS*sps_pkg::NUM_SEGS-1];
  logic [15:0] sp_mem [0:sps_pkg::NUM_PROGS*sps_pkg::NUM_SEGS-1];
  logic [3:0] trk_mem [0:sps_pkg::NUM_PROGS*sps_pkg::NUM_SEGS-1];

  function automatic logic [6:0] mem_idx(input logic [2:0] p,
                                         input logic [3:0] s);
    mem_idx = 7'(p * 12 + s);
  endfunction

  function automatic logic [15:0] absdiff(input logic [15:0] a,
                                          input logic [15:0] b);
    absdiff = ($signed(a) > $signed(b)) ? a - b : b - a;
  endfunction

  wire logic wr_ok = seg_we_in && (seg_addr_in < 4'(sps_pkg::NUM_SEGS));

  always_ff @(posedge clk_in) begin
    if (wr_ok) begin
      dur_mem[mem_idx(sequencer_enable_sel_in, seg_addr_in)] <= seg_dur_in;
      sp_mem[mem_idx(sequencer_enable_sel_in, seg_addr_in)] <= seg_sp_in;
      trk_mem[mem_idx(sequencer_enable_sel_in, seg_addr_in)] <= seg_trk_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, change counts when stages 2 and 3 agree
  logic [2:0] ss_sync_reg, ph_sync_reg, up_sync_reg, dn_sync_reg;
  logic [2:0] ack_sync_reg, dis_sync_reg;
  logic ss_reg, ph_reg, up_reg, dn_reg, ack_reg, dis_reg;
  logic up_old_reg, dn_old_reg, ack_old_reg, dis_old_reg;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ss_sync_reg <= 3'h0;
      ph_sync_reg <= 3'h0;
      up_sync_reg <= 3'h0;
      dn_sync_reg <= 3'h0;
      ack_sync_reg <= 3'h0;
      dis_sync_reg <= 3'h0;
      ss_reg <= 1'b0;
      ph_reg <= 1'b0;
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
      ack_reg <= 1'b0;
      dis_reg <= 1'b0;
      up_old_reg <= 1'b0;
      dn_old_reg <= 1'b0;
      ack_old_reg <= 1'b0;
      dis_old_reg <= 1'b0;
    end else begin
      ss_sync_reg <= {ss_sync_reg[1:0], start_stop_pin_in};
      ph_sync_reg <= {ph_sync_reg[1:0], external_pause_input};
      up_sync_reg <= {up_sync_reg[1:0], key_up_in};
      dn_sync_reg <= {dn_sync_reg[1:0], key_down_in};
      ack_sync_reg <= {ack_sync_reg[1:0], key_ack_in};
      dis_sync_reg <= {dis_sync_reg[1:0], key_discard_in};
      if (ss_sync_reg[1] == ss_sync_reg[2]) ss_reg <= ss_sync_reg[2];
      if (ph_sync_reg[1] == ph_sync_reg[2]) ph_reg <= ph_sync_reg[2];
      if (up_sync_reg[1] == up_sync_reg[2]) up_reg <= up_sync_reg[2];
      if (dn_sync_reg[1] == dn_sync_reg[2]) dn_reg <= dn_sync_reg[2];
      if (ack_sync_reg[1] == ack_sync_reg[2]) ack_reg <= ack_sync_reg[2];
      if (dis_sync_reg[1] == dis_sync_reg[2]) dis_reg <= dis_sync_reg[2];
      up_old_reg <= up_reg;
      dn_old_reg <= dn_reg;
      ack_old_reg <= ack_reg;
      dis_old_reg <= dis_reg;
    end
  end

  wire logic up_press = up_reg && !up_old_reg;
  wire logic dn_press = dn_reg && !dn_old_reg;
  wire logic ack_press = ack_reg && !ack_old_reg;
  wire logic dis_press = dis_reg && !dis_old_reg;

  ////////////////////////////////////////////////////////////////////////
  // Segment time base: one enable per second
  logic [24:0] div_reg;
  wire logic tick = (div_reg == 25'(TICK_DIV - 1));

  always_ff @(posedge clk_in) begin
    if (reset_in || tick) div_reg <= 25'h0000000;
    else div_reg <= div_reg + 25'h0000001;
  end

  ////////////////////////////////////////////////////////////////////////
  // Key selection with acknowledge window
  logic [1:0] key_sel_reg;
  logic key_pend_reg;
  logic [27:0] ack_cnt_reg;
  sps_pkg::sps_state_e state_reg;

  wire logic keys_allowed = sequencer_enable &&
    !start_input_cfg_in && !pause_input_cfg_in;
  wire logic ack_expired = (ack_cnt_reg == 28'(ACK_CYCLES - 1));
  wire logic key_commit = key_pend_reg && ack_press && !ack_expired;
  wire logic [1:0] key_step_up = (key_sel_reg == 2'h2) ? 2'h0 :
                                 key_sel_reg + 2'h1;
  wire logic [1:0] key_step_dn = (key_sel_reg == 2'h0) ? 2'h2 :
                                 key_sel_reg - 2'h1;

  always_ff @(posedge clk_in) begin
    if (reset_in || !keys_allowed) begin
      key_pend_reg <= 1'b0;
      key_sel_reg <= 2'h0;
      ack_cnt_reg <= 28'h0000000;
    end else if (up_press || dn_press) begin
      key_pend_reg <= 1'b1;
      key_sel_reg <= up_press ? key_step_up : key_step_dn;
      ack_cnt_reg <= 28'h0000000;
    end else if (key_commit || dis_press || ack_expired) begin
      key_pend_reg <= 1'b0;
      ack_cnt_reg <= 28'h0000000;
    end else if (key_pend_reg) begin
      ack_cnt_reg <= ack_cnt_reg + 28'h0000001;
    end
  end

  // Key choices: 0 stop, 1 run, 2 pause
  wire logic key_stop = key_commit && key_sel_reg == 2'h0;
  wire logic key_run = key_commit && key_sel_reg == 2'h1;
  wire logic key_pause = key_commit && key_sel_reg == 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // Sequence control
  logic [3:0] seg_reg;
  logic [13:0] elapsed_reg;
  logic [15:0] sp_reg;
  logic [15:0] start_sp_reg;
  logic ss_old_reg;

  wire logic ss_rise = start_input_cfg_in && ss_reg && !ss_old_reg;
  wire logic ss_fall = start_input_cfg_in && !ss_reg && ss_old_reg;
  wire logic do_start = ss_rise || key_run;
  wire logic do_stop = ss_fall || key_stop || !sequencer_enable;
  wire logic do_pause = (pause_input_cfg_in && ph_reg) || key_pause;
  wire logic do_resume = pause_input_cfg_in ? !ph_reg : key_run;

  wire logic [6:0] cur_idx = mem_idx(sequencer_enable_sel_in, seg_reg);
  wire logic [13:0] cur_dur = dur_mem[cur_idx];
  wire logic [15:0] cur_sp = sp_mem[cur_idx];
  wire logic [3:0] cur_trk = trk_mem[cur_idx];
  wire logic [13:0] dur_eff = (cur_dur > sps_pkg::DUR_MAX) ?
                              sps_pkg::DUR_MAX : cur_dur;
  wire logic seg_done = (elapsed_reg >= dur_eff);
  wire logic settled = absdiff(actual_in, sp_reg) <=
                       sps_pkg::SETTLE_BAND;
  wire logic last_seg = (seg_reg == 4'(sps_pkg::NUM_SEGS - 1));
  wire logic [6:0] nxt_idx = mem_idx(sequencer_enable_sel_in, seg_reg + 4'h1);
  wire logic next_is_end = last_seg ||
    (dur_mem[nxt_idx] == sps_pkg::DUR_END);
  wire logic first_is_end = (cur_dur == sps_pkg::DUR_END);

  // Linear interpolation; divide is combinational and evaluated every clock
  wire logic signed [31:0] ramp_span = 32'($signed(cur_sp)) -
                                      32'($signed(start_sp_reg));
  wire logic signed [31:0] ramp_prod = ramp_span *
                                      $signed({18'h0, elapsed_reg});
  wire logic signed [31:0] ramp_q = (dur_eff == 14'h0000) ? ramp_span :
    ramp_prod / $signed({18'h0, dur_eff});
  wire logic [15:0] ramp_sp = 16'(32'($signed(start_sp_reg)) + ramp_q);
  wire logic [15:0] live_sp = jump_segment_type ? cur_sp : ramp_sp;

  wire logic advance = seg_done &&
    (state_reg == sps_pkg::SPS_RUN || state_reg == sps_pkg::SPS_SETTLE) &&
    (!wait_enable_in || settled);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_reg <= sps_pkg::SPS_IDLE;
      seg_reg <= sps_pkg::SEG_FIRST;
      elapsed_reg <= 14'h0000;
      sp_reg <= sps_pkg::SP_RESET;
      start_sp_reg <= sps_pkg::SP_RESET;
      ss_old_reg <= 1'b0;
    end else begin
      ss_old_reg <= ss_reg;
      unique case (state_reg)
        sps_pkg::SPS_IDLE: begin
          sp_reg <= actual_in;
          seg_reg <= sps_pkg::SEG_FIRST;
          elapsed_reg <= 14'h0000;
          if (do_start && sequencer_enable && !first_is_end) begin
            state_reg <= sps_pkg::SPS_RUN;
            start_sp_reg <= actual_in;
          end
        end
        sps_pkg::SPS_RUN, sps_pkg::SPS_SETTLE: begin
          if (do_stop) begin
            state_reg <= sps_pkg::SPS_IDLE;
          end else if (do_pause) begin
            state_reg <= sps_pkg::SPS_PAUSE;
          end else if (advance) begin
            if (next_is_end) begin
              state_reg <= sps_pkg::SPS_IDLE;
            end else begin
              state_reg <= sps_pkg::SPS_RUN;
              seg_reg <= seg_reg + 4'h1;
              elapsed_reg <= 14'h0000;
              start_sp_reg <= cur_sp;
              sp_reg <= cur_sp;
            end
          end else begin
            sp_reg <= live_sp;
            if (seg_done) state_reg <= sps_pkg::SPS_SETTLE;
            else if (tick) elapsed_reg <= elapsed_reg + 14'h0001;
          end
        end
        sps_pkg::SPS_PAUSE: begin
          if (do_stop) state_reg <= sps_pkg::SPS_IDLE;
          else if (do_resume) state_reg <= sps_pkg::SPS_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  wire logic active = (state_reg != sps_pkg::SPS_IDLE);

  assign setpoint_out = sp_reg;
  assign setpoint_dashes_out = sequencer_enable && !active;
  assign setpoint_lock_out = sequencer_enable;
  assign tune_block_out = sequencer_enable;
  assign ctrl_enable_out = active;
  assign limit_err_enable_out = active;
  assign segment_flag_output = active ? cur_trk : 4'h0;
  assign run_ind_out = (state_reg == sps_pkg::SPS_RUN) ||
                       (state_reg == sps_pkg::SPS_SETTLE);
  assign pause_ind_out = (state_reg == sps_pkg::SPS_PAUSE);
  assign status_state_out = state_reg;
  assign status_seg_out = active ? seg_reg + 4'h1 : 4'h0;
  assign key_pending_out = key_pend_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_idle_outputs_off: assert property (@(posedge clk_in) disable iff
    (reset_in) !active |-> !ctrl_enable_out && !limit_err_enable_out &&
    segment_flag_output == 4'h0) else $error("idle outputs active");
  a_idle_tracks_pv: assert property (@(posedge clk_in) disable iff
    (reset_in) state_reg == sps_pkg::SPS_IDLE && $past(state_reg) ==
    sps_pkg::SPS_IDLE |-> sp_reg == $past(actual_in))
    else $error("idle setpoint not actual");
  a_start_seg_one: assert property (@(posedge clk_in) disable iff
    (reset_in) $rose(run_ind_out) && $past(state_reg) ==
    sps_pkg::SPS_IDLE |-> status_seg_out == 4'h1 &&
    start_sp_reg == $past(actual_in))
    else $error("start not at segment 1");
  a_pause_freezes: assert property (@(posedge clk_in) disable iff
    (reset_in) pause_ind_out && $past(pause_ind_out) |->
    $stable(sp_reg) && $stable(elapsed_reg) && $stable(seg_reg))
    else $error("pause not frozen");
  a_pause_pin_halts: assert property (@(posedge clk_in) disable iff
    (reset_in) run_ind_out && pause_input_cfg_in && ph_reg &&
    sequencer_enable |=> pause_ind_out || !active)
    else $error("halt pin ignored");
  a_settle_waits: assert property (@(posedge clk_in) disable iff
    (reset_in) state_reg == sps_pkg::SPS_SETTLE && wait_enable_in &&
    !settled && !do_stop && !do_pause |=> $stable(seg_reg))
    else $error("advanced before settle");
  a_keys_locked: assert property (@(posedge clk_in) disable iff
    (reset_in) start_input_cfg_in |-> !key_pend_reg)
    else $error("keys active with pin control");
  a_ack_window: assert property (@(posedge clk_in) disable iff
    (reset_in) key_pend_reg && ack_expired |=> !key_pend_reg)
    else $error("pending change kept");
  a_dash_display: assert property (@(posedge clk_in) disable iff
    (reset_in) sequencer_enable && !active |-> setpoint_dashes_out)
    else $error("no dashes when ended");
  a_status_seg: assert property (@(posedge clk_in) disable iff
    (reset_in) active |-> status_seg_out == seg_reg + 4'h1)
    else $error("segment not reported");

  c_run_start: cover property (@(posedge clk_in) $rose(run_ind_out));
  c_pause: cover property (@(posedge clk_in) $rose(pause_ind_out));
  c_settle: cover property (@(posedge clk_in)
    state_reg == sps_pkg::SPS_SETTLE);
  c_key_commit: cover property (@(posedge clk_in) key_commit);

endmodule

`default_nettype wire

// >>> test/sps_partner.sv
// Binary inputs, front keys and relay model facing the sequencer
`timescale 1ns/1ns
`default_nettype none

module sps_partner (
  // Clock
  input wire logic clk_in,
  // Binary inputs and keys: up, down, ack, discard
  output logic start_pin_out,
  output logic pause_pin_out,
  output logic [3:0] keys_out,
  // Relays
  input wire logic run_relay_in,
  input wire logic pause_relay_in
);
  int run_closures = 0;
  int pause_closures = 0;
  logic run_q = 1'b0;
  logic pause_q = 1'b0;

  initial begin
    start_pin_out = 1'b0;
    pause_pin_out = 1'b0;
    keys_out = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Levels are held long enough to pass the pin synchronisers
  task set_start(input logic v);
    @(posedge clk_in);
    start_pin_out <= v;
    repeat (8) @(posedge clk_in);
  endtask

  task set_pause(input logic v);
    @(posedge clk_in);
    pause_pin_out <= v;
    repeat (8) @(posedge clk_in);
  endtask

  task press(input int k);
    @(posedge clk_in);
    keys_out[k] <= 1'b1;
    repeat (8) @(posedge clk_in);
    keys_out[k] <= 1'b0;
    repeat (8) @(posedge clk_in);
    // Leave on a falling edge so callers read settled outputs
    @(negedge clk_in);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Relay closures counted like a lamp counter would
  always @(posedge clk_in) begin
    run_q <= run_relay_in;
    pause_q <= pause_relay_in;
    if (run_relay_in && !run_q) run_closures++;
    if (pause_relay_in && !pause_q) pause_closures++;
  end
endmodule

`default_nettype wire

// >>> test/test_sps_sequencer.sv
// Self-checking bench for the setpoint program sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) \
  begin \
    num_checks++; \
    if ((a) !== (b)) begin \
      error_cnt++; \
      $display("BAD t=%0t got %h exp %h", $time, a, b); \
    end \
  end

module test_sps_sequencer;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic sequencer_enable = 1'b0;
  logic wait_enable_in = 1'b0;
  logic jump_segment_type = 1'b1;
  logic [2:0] sequencer_enable_sel_in = 3'h3;
  logic start_input_cfg_in = 1'b1;
  logic pause_input_cfg_in = 1'b1;
  logic [3:0] seg_addr_in = 4'h0;
  logic [13:0] seg_dur_in = 14'h0000;
  logic [15:0] seg_sp_in = 16'h0000;
  logic [3:0] seg_trk_in = 4'h0;
  logic seg_we_in = 1'b0;
  logic [15:0] actual_in = 16'h0000;
  wire logic start_pin, pause_pin, dashes, lock, tune, ctrl, lim;
  wire logic run_ind, pause_ind, pend;
  wire logic [3:0] keys, trk, sg;
  wire logic [1:0] st;
  wire logic [15:0] sp;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [31:0] rng = 32'd64296;
  logic [15:0] m_sp [8][12];
  logic [3:0] m_trk [8][12];
  logic [15:0] held;

  sps_sequencer #(.ACK_CYCLES(200), .TICK_DIV(10)) sps_sequencer_i (
    .clk_in(clk_in), .reset_in(reset_in),
    .sequencer_enable(sequencer_enable), .wait_enable_in(wait_enable_in),
    .jump_segment_type(jump_segment_type), .sequencer_enable_sel_in(sequencer_enable_sel_in),
    .start_input_cfg_in(start_input_cfg_in),
    .pause_input_cfg_in(pause_input_cfg_in), .seg_addr_in(seg_addr_in),
    .seg_dur_in(seg_dur_in), .seg_sp_in(seg_sp_in), .seg_trk_in(seg_trk_in),
    .seg_we_in(seg_we_in), .start_stop_pin_in(start_pin),
    .external_pause_input(pause_pin), .key_up_in(keys[0]),
    .key_down_in(keys[1]), .key_ack_in(keys[2]), .key_discard_in(keys[3]),
    .actual_in(actual_in), .setpoint_out(sp), .setpoint_dashes_out(dashes),
    .setpoint_lock_out(lock), .tune_block_out(tune),
    .ctrl_enable_out(ctrl), .limit_err_enable_out(lim),
    .segment_flag_output(trk), .run_ind_out(run_ind),
    .pause_ind_out(pause_ind), .status_state_out(st), .status_seg_out(sg),
    .key_pending_out(pend));

  sps_partner sps_partner_i (.clk_in(clk_in), .start_pin_out(start_pin),
    .pause_pin_out(pause_pin), .keys_out(keys), .run_relay_in(run_ind),
    .pause_relay_in(pause_ind));

  initial begin
    forever #20 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[15:0] & 16'h03FF;
  endfunction

  task step(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task wr(input int p, input int s, input logic [13:0] d, input logic [3:0] t);
    @(posedge clk_in);
    m_sp[p][s] = rnd();
    m_trk[p][s] = t;
    sequencer_enable_sel_in <= p[2:0];
    seg_addr_in <= s[3:0];
    seg_dur_in <= d;
    seg_sp_in <= m_sp[p][s];
    seg_trk_in <= t;
    seg_we_in <= 1'b1;
    @(posedge clk_in);
    seg_we_in <= 1'b0;
  endtask

  // Bounded wait for a status, then compare it
  task wait_st(input logic [1:0] e_st, input logic [3:0] e_sg, input int lim);
    int i;
    i = 0;
    @(negedge clk_in);
    while (i < lim && !(st === e_st && sg === e_sg)) begin
      @(negedge clk_in);
      i++;
    end
    `CHK(st, e_st)
    `CHK(sg, e_sg)
  endtask

  task chk_run(input int p, input int s);
    step(3);
    @(negedge clk_in);
    `CHK(trk, m_trk[p][s-1])
    `CHK(sp, m_sp[p][s-1])
    `CHK({ctrl, lim, run_ind, pause_ind}, 4'hE)
  endtask

  task chk_idle();
    step(3);
    @(negedge clk_in);
    `CHK({st, sg, trk}, 10'h000)
    `CHK({ctrl, lim, run_ind, pause_ind}, 4'h0)
    `CHK(sp, actual_in)
    `CHK(dashes, sequencer_enable)
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    step(2);
    reset_in <= 1'b0;
    sequencer_enable <= 1'b1;
    actual_in <= rnd();
    chk_idle();
    `CHK({lock, tune}, 2'h3)
    wr(3, 0, 14'h0002, 4'h1);
    wr(3, 1, 14'h0001, 4'hA);
    wr(3, 2, sps_pkg::DUR_END, 4'h0);
    wr(4, 0, 14'h0003, 4'h5);
    wr(4, 1, 14'h0064, 4'h6);
    wr(4, 2, sps_pkg::DUR_END, 4'h0);
    wr(5, 0, sps_pkg::DUR_END, 4'h0);
    // Start refused on an empty program
    sps_partner_i.set_start(1'b1);
    step(20);
    @(negedge clk_in);
    `CHK(st, sps_pkg::SPS_IDLE)
    sps_partner_i.set_start(1'b0);
    sequencer_enable_sel_in <= 3'h3;
    sps_partner_i.set_start(1'b1);
    wait_st(sps_pkg::SPS_RUN, 4'h1, 20);
    chk_run(3, 1);
    wait_st(sps_pkg::SPS_RUN, 4'h2, 60);
    chk_run(3, 2);
    wait_st(sps_pkg::SPS_IDLE, 4'h0, 60);
    chk_idle();
    $display("test program run done");
    sps_partner_i.set_start(1'b0);
    sequencer_enable_sel_in <= 3'h4;
    sps_partner_i.set_start(1'b1);
    wait_st(sps_pkg::SPS_RUN, 4'h2, 80);
    sps_partner_i.set_pause(1'b1);
    wait_st(sps_pkg::SPS_PAUSE, 4'h2, 20);
    held = sp;
    actual_in <= rnd();
    step(40);
    @(negedge clk_in);
    `CHK({st, sg, sp}, {sps_pkg::SPS_PAUSE, 4'h2, held})
    `CHK({run_ind, pause_ind}, 2'h1)
    sps_partner_i.set_pause(1'b0);
    wait_st(sps_pkg::SPS_RUN, 4'h2, 20);
    sps_partner_i.set_start(1'b0);
    wait_st(sps_pkg::SPS_IDLE, 4'h0, 20);
    chk_idle();
    sps_partner_i.set_start(1'b1);
    wait_st(sps_pkg::SPS_RUN, 4'h1, 20);
    sps_partner_i.set_start(1'b0);
    wait_st(sps_pkg::SPS_IDLE, 4'h0, 20);
    $display("test pause and restart done");
    wait_enable_in <= 1'b1;
    jump_segment_type <= 1'b0;
    sequencer_enable_sel_in <= 3'h3;
    actual_in <= m_sp[3][0] + 16'h0010;
    sps_partner_i.set_start(1'b1);
    wait_st(sps_pkg::SPS_SETTLE, 4'h1, 60);
    step(30);
    @(negedge clk_in);
    `CHK(st, sps_pkg::SPS_SETTLE)
    actual_in <= m_sp[3][0] + 16'h0002;
    wait_st(sps_pkg::SPS_RUN, 4'h2, 20);
    actual_in <= m_sp[3][1];
    wait_st(sps_pkg::SPS_IDLE, 4'h0, 60);
    wait_enable_in <= 1'b0;
    jump_segment_type <= 1'b1;
    sps_partner_i.set_start(1'b0);
    $display("test settle done");
    start_input_cfg_in <= 1'b0;
    pause_input_cfg_in <= 1'b0;
    sequencer_enable_sel_in <= 3'h4;
    sps_partner_i.press(0);
    `CHK(pend, 1'b1)
    step(150);
    sps_partner_i.press(2);
    wait_st(sps_pkg::SPS_RUN, 4'h1, 20);
    sps_partner_i.press(0);
    sps_partner_i.press(3);
    `CHK({pend, st}, {1'b0, sps_pkg::SPS_RUN})
    sps_partner_i.press(0);
    step(220);
    @(negedge clk_in);
    `CHK({pend, st}, {1'b0, sps_pkg::SPS_RUN})
    // Expired choice was stop; two steps up reach pause
    sps_partner_i.press(0);
    sps_partner_i.press(0);
    sps_partner_i.press(2);
    wait_st(sps_pkg::SPS_PAUSE, 4'h2, 20);
    sps_partner_i.press(1);
    sps_partner_i.press(2);
    wait_st(sps_pkg::SPS_RUN, 4'h2, 20);
    sps_partner_i.press(0);
    sps_partner_i.press(0);
    sps_partner_i.press(2);
    wait_st(sps_pkg::SPS_IDLE, 4'h0, 20);
    start_input_cfg_in <= 1'b1;
    sps_partner_i.press(0);
    `CHK(pend, 1'b0)
    `CHK(sps_partner_i.run_closures, 7)
    `CHK(sps_partner_i.pause_closures, 2)
    sequencer_enable <= 1'b0;
    step(3);
    @(negedge clk_in);
    `CHK({lock, tune, dashes, st}, 5'h00)
    $display("test keys done");
    results();
  end

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 12000) begin
      error_cnt++;
      results();
    end
  end

  task results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
endmodule

`default_nettype wire
